// File: hw/dmem_cfg.svh
// Address map constants for the data memory block
`ifndef DMEM_CFG_SVH
`define DMEM_CFG_SVH

// Internal RAM boundaries
`define DM_LO_HALF_END   8'h7f
`define DM_BIT_BYTE_BASE 4'h2
`define DM_SHADOW_END    8'h2f
`define DM_SHADOW_N      48

// Stack pointer reset value
`define DM_STACK_RST     8'h07

// Locally held special function register addresses
`define DM_SFR_STACK     8'h81
`define DM_SFR_PTR_LO    8'h82
`define DM_SFR_PTR_HI    8'h83
`define DM_SFR_PAGE      8'haa
`define DM_SFR_STATUS    8'hd0

// Bank select field of the program status word
`define DM_BANK_SEL_LO   3
`define DM_BANK_SEL_HI   4

// Shared memory: external RAM at the bottom, internal RAM above it
`define DM_MEM_DEPTH     4352
`define DM_MEM_AW        13
`define DM_IRAM_BASE     13'h1000
`define DM_XMASK_BIG     12'hfff
`define DM_XMASK_SMALL   12'h1ff

`endif

// File: hw/dmem_pkg.sv
// Types shared by the data memory block
package dmem_pkg;

  // Kind of access requested by the execution unit
  typedef enum logic [2:0] {
    AK_DIRECT   = 3'h0,
    AK_INDIRECT = 3'h1,
    AK_REG      = 3'h2,
    AK_BIT      = 3'h3,
    AK_PUSH     = 3'h4,
    AK_POP      = 3'h5,
    AK_XDPTR    = 3'h6,
    AK_XPAGE    = 3'h7
  } acc_kind_t;

  // Special function registers held inside this block
  typedef enum logic [2:0] {
    SFR_NONE = 3'h0,
    SFR_STACK  = 3'h1,
    SFR_PTR_LO = 3'h2,
    SFR_PTR_HI = 3'h3,
    SFR_PAGE   = 3'h4,
    SFR_STATUS = 3'h5
  } sfr_id_t;

endpackage

// File: hw/byte_ram.sv
// Byte memory with registered read data and a bypass into that register
`include "dmem_cfg.svh"
module byte_ram
  import dmem_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  we_i,
  input  wire logic [`DM_MEM_AW-1:0] addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  byp_i,
  input  wire logic [7:0]            byp_data_i,
  output logic      [7:0]            rdata_o
);

  logic [7:0] mem_q [`DM_MEM_DEPTH];

  // Write port, no initialisation needed before use
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  // Read register, old data on a same-address write
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= byp_i ? byp_data_i : mem_q[addr_i];
    end
  end

endmodule

// File: hw/low_regs.sv
// Flop array for bytes 0x00-0x2f: register banks and bit area
`include "dmem_cfg.svh"
module low_regs
  import dmem_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic [5:0] addr_i,
  input  wire logic       we_i,
  input  wire logic       bit_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [1:0] bank_i,
  output logic      [7:0] rd_byte_o,
  output logic            rd_bit_o,
  output logic      [7:0] ri0_o,
  output logic      [7:0] ri1_o
);

  logic [7:0] byte_q [`DM_SHADOW_N];

  // One byte per location; a bit write touches only its own bit
  genvar g;
  generate
    for (g = 0; g < `DM_SHADOW_N; g++) begin : g_byte
      wire hit = we_i && (addr_i == 6'(g));
      always_ff @(posedge sys_clk_i) begin
        if (hit && bit_i) begin
          byte_q[g][bit_sel_i] <= wdata_i[0];
        end else if (hit) begin
          byte_q[g] <= wdata_i;
        end
      end
    end
  endgenerate

  // Read paths; index registers come from the active bank
  assign rd_byte_o = byte_q[addr_i];
  assign rd_bit_o  = rd_byte_o[bit_sel_i];
  assign ri0_o     = byte_q[{1'b0, bank_i, 3'h0}];
  assign ri1_o     = byte_q[{1'b0, bank_i, 3'h1}];

endmodule

// File: hw/dmem_map.sv
// Data memory address map: internal RAM, stack, pointers, external RAM
// Operation
// - Internal RAM holds 256 bytes at addresses 0x00 to 0xff.
// - Lower 128 bytes are reached by direct and indirect accesses.
// - Bytes 0x00-0x1f form four banks of eight registers each.
// - Bytes 0x20-0x2f are reachable as bytes and as 128 bits.
// - Upper 128 bytes only indirectly, stored apart from special registers.
// - Direct access above 0x7f goes to special function registers.
// - Indirect access above 0x7f goes to upper internal RAM.
// - One bank active, chosen by status word bits 3 and 4.
// - Indirect address comes from register zero or one of active bank.
// - Bit address n maps to byte 0x20 plus n/8, bit n mod 8.
// - Bit versus byte access is decided by the access kind only.
// - Push writes at stack pointer plus one, then pointer increments.
// - Reset loads stack pointer with 0x07.
// - Stack may sit anywhere in the 256 bytes, full depth.
// - External RAM of 4096 bytes, or 512 on the small variant.
// - Pointer form of external move uses the full 16-bit data pointer.
// - Paged form uses page select as high byte, index register low.
// - Data pointer is readable and writable as high and low bytes.
// - External moves hit external RAM; only writes may go to flash.
// - External RAM needs no initialisation after reset.
// - Page select keeps four bits; upper four read zero.
// - Bank codes 00..11 select bytes 0x00, 0x08, 0x10, 0x18 onward.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`include "dmem_cfg.svh"
module dmem_map
  import dmem_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       small_variant_i,
  input  wire logic       flash_redir_i,
  input  wire acc_kind_t  kind_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic      [7:0] stack_pointer_o,
  output logic     [15:0] data_pointer_o,
  output logic      [7:0] status_word_o,
  output logic      [3:0] page_o,
  output logic            sfr_fwd_o,
  output logic            sfr_wr_o,
  output logic            sfr_bit_o,
  output logic      [7:0] sfr_addr_o,
  output logic      [7:0] fwd_data_o,
  output logic            flash_wr_o,
  output logic     [15:0] flash_addr_o
);

  // Architectural registers held here
  logic [7:0]  stack_pointer_q;
  logic [7:0]  stack_pointer_d;
  logic [15:0] data_pointer_word_q;
  logic [15:0] data_pointer_word_d;
  logic [7:0]  program_status_word_q;
  logic [7:0]  program_status_word_d;
  logic [3:0]  page_number_field_q;
  logic [3:0]  page_number_field_d;
  logic        small_q;

  // Forwarding registers
  logic        sfr_fwd_q;
  logic        sfr_wr_q;
  logic        sfr_bit_q;
  logic [7:0]  sfr_addr_q;
  logic [7:0]  fwd_data_q;
  logic        flash_wr_q;
  logic [15:0] flash_addr_q;

  // Maps a special register address onto the locally held ones
  function automatic sfr_id_t own_sfr(input logic [7:0] a);
    sfr_id_t id;
    id = SFR_NONE;
    if (a == `DM_SFR_STACK) begin
      id = SFR_STACK;
    end else if (a == `DM_SFR_PTR_LO) begin
      id = SFR_PTR_LO;
    end else if (a == `DM_SFR_PTR_HI) begin
      id = SFR_PTR_HI;
    end else if (a == `DM_SFR_PAGE) begin
      id = SFR_PAGE;
    end else if (a == `DM_SFR_STATUS) begin
      id = SFR_STATUS;
    end
    return id;
  endfunction

  // Access kind decode
  wire is_bit   = (kind_i == AK_BIT);
  wire is_push  = (kind_i == AK_PUSH);
  wire is_pop   = (kind_i == AK_POP);
  wire is_xdptr = (kind_i == AK_XDPTR);
  wire is_x     = is_xdptr || (kind_i == AK_XPAGE);

  // Active bank from the status word
  wire [1:0] bank_sel_high_low =
    program_status_word_q[`DM_BANK_SEL_HI:`DM_BANK_SEL_LO];

  // Index registers of the active bank
  logic [7:0] index_register_zero;
  logic [7:0] index_register_one;
  wire  [7:0] ri_val = addr_i[0] ? index_register_one
                                 : index_register_zero;

  // Special register space: direct and bit addresses above 0x7f
  wire        is_sfr   = (kind_i == AK_DIRECT || is_bit) && addr_i[7];
  wire  [7:0] bit_byte = {addr_i[7:3], 3'h0};
  wire  [7:0] sfr_addr = is_bit ? bit_byte : addr_i;
  wire sfr_id_t sfr_id = own_sfr(sfr_addr);
  wire        sfr_own  = is_sfr && (sfr_id != SFR_NONE);

  // Internal RAM address for each access kind
  wire [7:0] bank_reg = {3'h0, bank_sel_high_low, addr_i[2:0]};
  wire [7:0] bit_ram  = {`DM_BIT_BYTE_BASE, addr_i[6:3]};
  wire [7:0] stack_inc = stack_pointer_q + 8'h01;
  wire [7:0] stack_dec = stack_pointer_q - 8'h01;
  wire [7:0] iaddr    =
    (kind_i == AK_REG)      ? bank_reg :
    (kind_i == AK_INDIRECT) ? ri_val   :
    is_bit                  ? bit_ram  :
    is_push                 ? stack_inc :
    is_pop                  ? stack_pointer_q :
                              addr_i;

  // Bytes 0x00-0x2f live in flops, the rest in the shared memory
  wire lo_hit = !is_sfr && !is_x && (iaddr <= `DM_SHADOW_END);

  // External address in both forms, masked to the fitted size
  wire [15:0] xaddr16 = is_xdptr ? data_pointer_word_q
                                 : {4'h0, page_number_field_q, ri_val};
  wire [11:0] xmask   = small_q ? `DM_XMASK_SMALL : `DM_XMASK_BIG;
  wire [11:0] x_off   = xaddr16[11:0] & xmask;

  // Flash redirection diverts writes only; reads stay on RAM
  wire redir = is_x && wr_i && flash_redir_i;

  // Shared memory address and write enable
  wire [`DM_MEM_AW-1:0] mem_addr =
    is_x ? {1'b0, x_off} : (`DM_IRAM_BASE | {5'h00, iaddr});
  wire mem_we = wr_i && !is_sfr && !lo_hit && !redir;

  // Current value of the addressed local special register
  wire [7:0] sfr_byte =
    (sfr_id == SFR_STACK)  ? stack_pointer_q :
    (sfr_id == SFR_PTR_LO) ? data_pointer_word_q[7:0] :
    (sfr_id == SFR_PTR_HI) ? data_pointer_word_q[15:8] :
    (sfr_id == SFR_PAGE)   ? {4'h0, page_number_field_q} :
    (sfr_id == SFR_STATUS) ? program_status_word_q :
                           8'h00;

  // Bit merge for bit writes into local special registers
  wire [7:0] bit_mask = 8'h01 << addr_i[2:0];
  wire [7:0] bit_set  = wdata_i[0] ? bit_mask : 8'h00;
  wire [7:0] sfr_new  = is_bit ? ((sfr_byte & ~bit_mask) | bit_set)
                               : wdata_i;

  // Flop array read values
  logic [7:0] lo_byte;
  logic       lo_bit;

  // Bypass data for reads not served by the shared memory
  wire [7:0] sfr_rd   = is_bit ? {7'h00, sfr_byte[addr_i[2:0]]} : sfr_byte;
  wire [7:0] lo_rd    = is_bit ? {7'h00, lo_bit} : lo_byte;
  wire       byp      = is_sfr || lo_hit;
  wire [7:0] byp_data = is_sfr ? sfr_rd : lo_rd;

  // Local register write enables
  wire wr_stack  = wr_i && sfr_own && (sfr_id == SFR_STACK);
  wire wr_ptr_lo = wr_i && sfr_own && (sfr_id == SFR_PTR_LO);
  wire wr_ptr_hi = wr_i && sfr_own && (sfr_id == SFR_PTR_HI);
  wire wr_page   = wr_i && sfr_own && (sfr_id == SFR_PAGE);
  wire wr_status = wr_i && sfr_own && (sfr_id == SFR_STATUS);

  // Next values: push increments, pop decrements, direct writes load
  assign stack_pointer_d =
    (is_push && wr_i) ? stack_inc :
    (is_pop && rd_i)  ? stack_dec :
    wr_stack          ? sfr_new :
                        stack_pointer_q;
  assign data_pointer_word_d = {
    wr_ptr_hi ? sfr_new : data_pointer_word_q[15:8],
    wr_ptr_lo ? sfr_new : data_pointer_word_q[7:0]};
  assign page_number_field_d =
    wr_page ? sfr_new[3:0] : page_number_field_q;
  assign program_status_word_d =
    wr_status ? sfr_new : program_status_word_q;

  // Architectural registers; the variant strap is caught during reset
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      stack_pointer_q       <= `DM_STACK_RST;
      data_pointer_word_q   <= 16'h0000;
      program_status_word_q <= 8'h00;
      page_number_field_q   <= 4'h0;
      small_q               <= small_variant_i;
    end else begin
      stack_pointer_q       <= stack_pointer_d;
      data_pointer_word_q   <= data_pointer_word_d;
      program_status_word_q <= program_status_word_d;
      page_number_field_q   <= page_number_field_d;
    end
  end

  // Forward foreign special register accesses and flash writes
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sfr_fwd_q    <= 1'b0;
      sfr_wr_q     <= 1'b0;
      sfr_bit_q    <= 1'b0;
      sfr_addr_q   <= 8'h00;
      fwd_data_q   <= 8'h00;
      flash_wr_q   <= 1'b0;
      flash_addr_q <= 16'h0000;
    end else begin
      sfr_fwd_q    <= (wr_i || rd_i) && is_sfr && !sfr_own;
      sfr_wr_q     <= wr_i;
      sfr_bit_q    <= is_bit;
      sfr_addr_q   <= addr_i;
      fwd_data_q   <= wdata_i;
      flash_wr_q   <= redir;
      flash_addr_q <= xaddr16;
    end
  end

  // Registers 0x00-0x2f with bit access
  low_regs u_low_regs (
    .sys_clk_i (sys_clk_i),
    .addr_i    (iaddr[5:0]),
    .we_i      (wr_i && lo_hit),
    .bit_i     (is_bit),
    .bit_sel_i (addr_i[2:0]),
    .wdata_i   (wdata_i),
    .bank_i    (bank_sel_high_low),
    .rd_byte_o (lo_byte),
    .rd_bit_o  (lo_bit),
    .ri0_o     (index_register_zero),
    .ri1_o     (index_register_one)
  );

  // Internal RAM above 0x2f and external RAM in one memory
  byte_ram u_byte_ram (
    .sys_clk_i  (sys_clk_i),
    .srst_i     (srst_i),
    .we_i       (mem_we),
    .addr_i     (mem_addr),
    .wdata_i    (wdata_i),
    .byp_i      (byp),
    .byp_data_i (byp_data),
    .rdata_o    (rdata_o)
  );

  // Outputs straight from registers
  assign stack_pointer_o = stack_pointer_q;
  assign data_pointer_o  = data_pointer_word_q;
  assign status_word_o   = program_status_word_q;
  assign page_o       = page_number_field_q;
  assign sfr_fwd_o    = sfr_fwd_q;
  assign sfr_wr_o     = sfr_wr_q;
  assign sfr_bit_o    = sfr_bit_q;
  assign sfr_addr_o   = sfr_addr_q;
  assign fwd_data_o   = fwd_data_q;
  assign flash_wr_o   = flash_wr_q;
  assign flash_addr_o = flash_addr_q;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence push_s;
    is_push && wr_i;
  endsequence

  sequence pop_s;
    is_pop && rd_i;
  endsequence

  chk_push_stack_inc: assert property (
    push_s |=> stack_pointer_q == $past(stack_pointer_q) + 8'h01)
    else $error("stack pointer did not advance on push");

  chk_push_pop_data: assert property (
    push_s ##1 pop_s |=> rdata_o == $past(wdata_i, 2))
    else $error("popped byte differs from pushed byte");

  chk_stack_reset_load: assert property (
    disable iff (1'b0) srst_i |=> stack_pointer_q == 8'h07)
    else $error("stack pointer not 0x07 after reset");

  chk_direct_sfr_fwd: assert property (
    (kind_i == AK_DIRECT) && addr_i[7] && wr_i && !sfr_own
      |-> !mem_we ##1 sfr_fwd_o && sfr_addr_o == $past(addr_i))
    else $error("direct high access not sent to special space");

  chk_indirect_upper: assert property (
    (kind_i == AK_INDIRECT) && ri_val[7] && wr_i
      |-> mem_we && mem_addr == (13'h1000 | {5'h00, ri_val}))
    else $error("indirect high access missed upper RAM");

  chk_bank_reg_map: assert property (
    (kind_i == AK_REG)
      |-> iaddr == {3'h0, program_status_word_q[4:3], addr_i[2:0]})
    else $error("register number mapped to wrong bank byte");

  chk_bit_byte_map: assert property (
    is_bit && !addr_i[7] |-> lo_hit && iaddr == 8'h20 + {4'h0, addr_i[6:3]})
    else $error("bit address mapped to wrong byte");

  chk_page_upper_zero: assert property (
    (kind_i == AK_DIRECT) && addr_i == 8'haa && rd_i |=> rdata_o[7:4] == 4'h0)
    else $error("page select upper bits not zero");

  chk_xpage_addr: assert property (
    (kind_i == AK_XPAGE) && wr_i && !flash_redir_i
      |-> mem_we && mem_addr[11:0] == ({page_o, ri_val} & xmask))
    else $error("paged external address formed wrongly");

  chk_xdptr_addr: assert property (
    is_xdptr && rd_i |-> mem_addr == {1'b0, data_pointer_o[11:0] & xmask})
    else $error("pointer external address formed wrongly");

  chk_flash_redirect: assert property (
    is_x && wr_i && flash_redir_i
      |-> !mem_we ##1 flash_wr_o && flash_addr_o == $past(xaddr16))
    else $error("redirected write reached external RAM");

  chk_pop_stack_dec: assert property (
    pop_s |=> stack_pointer_q == $past(stack_pointer_q) - 8'h01)
    else $error("stack pointer did not step back on pop");

  chk_redir_read_ram: assert property (
    is_x && rd_i && flash_redir_i |=> !flash_wr_o)
    else $error("external read was sent to flash");

  chk_page_write_low: assert property (
    (kind_i == AK_DIRECT) && addr_i == `DM_SFR_PAGE && wr_i
      |=> {4'h0, page_o} == ($past(wdata_i) & 8'h0f))
    else $error("page select did not keep the low four bits");

  chk_ptr_high_write: assert property (
    (kind_i == AK_DIRECT) && addr_i == `DM_SFR_PTR_HI && wr_i
      |=> data_pointer_o[15:8] == $past(wdata_i))
    else $error("data pointer high byte not written");

endmodule

// File: verification/exec_unit_model.sv
// Execution unit model: issues one access at a time to the data memory block
module exec_unit_model
  import dmem_pkg::*;
(
  input  wire logic       sys_clk_i,
  output acc_kind_t       kind_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet request lines at time zero
  initial begin
    kind_o  = AK_DIRECT;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // One strobed access; idle gap lets a slow unit be modelled by the caller
  task automatic req(input acc_kind_t k, input logic [7:0] a, input logic [7:0] d,
                     input logic w);
    @(posedge sys_clk_i);
    kind_o  <= k;
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= w;
    rd_o    <= !w;
    @(posedge sys_clk_i);
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    addr_o  <= ~a;  // Released lines flip so stale values cannot pass
    wdata_o <= ~d;
    #1;
  endtask

  // Two strobed accesses on consecutive edges, with no idle cycle between them
  task automatic req_pair(input acc_kind_t k0, input logic [7:0] a0, input logic [7:0] d0,
                          input logic w0, input acc_kind_t k1, input logic [7:0] a1,
                          input logic [7:0] d1, input logic w1);
    @(posedge sys_clk_i);
    kind_o  <= k0;
    addr_o  <= a0;
    wdata_o <= d0;
    wr_o    <= w0;
    rd_o    <= !w0;
    @(posedge sys_clk_i);
    kind_o  <= k1;
    addr_o  <= a1;
    wdata_o <= d1;
    wr_o    <= w1;
    rd_o    <= !w1;
    @(posedge sys_clk_i);
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    addr_o  <= ~a1;
    wdata_o <= ~d1;
    #1;
  endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the data memory address map
module testbench
  import dmem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_i;
  logic        srst_i;
  logic        small_variant_i;
  logic        flash_redir_i;
  acc_kind_t   kind;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata_o;
  logic [7:0]  stack_pointer_o;
  logic [15:0] data_pointer_o;
  logic [7:0]  status_word_o;
  logic [3:0]  page_o;
  logic        sfr_fwd_o;
  logic        sfr_wr_o;
  logic        sfr_bit_o;
  logic [7:0]  sfr_addr_o;
  logic [7:0]  fwd_data_o;
  logic        flash_wr_o;
  logic [15:0] flash_addr_o;
  int          error_cnt;
  int          checked;

  dmem_map DUT (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .small_variant_i(small_variant_i),
    .flash_redir_i(flash_redir_i), .kind_i(kind), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o), .stack_pointer_o(stack_pointer_o),
    .data_pointer_o(data_pointer_o), .status_word_o(status_word_o), .page_o(page_o),
    .sfr_fwd_o(sfr_fwd_o), .sfr_wr_o(sfr_wr_o),
    .sfr_bit_o(sfr_bit_o), .sfr_addr_o(sfr_addr_o), .fwd_data_o(fwd_data_o),
    .flash_wr_o(flash_wr_o), .flash_addr_o(flash_addr_o));

  exec_unit_model eu (
    .sys_clk_i(sys_clk_i), .kind_o(kind), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));

  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Write and read accesses; reads compare the answer of the following cycle
  task automatic w(input acc_kind_t k, input logic [7:0] a, input logic [7:0] d);
    eu.req(k, a, d, 1'b1);
  endtask

  task automatic r(input acc_kind_t k, input logic [7:0] a, input logic [7:0] e);
    eu.req(k, a, 8'h00, 1'b0);
    check(16'(rdata_o), 16'(e));
  endtask

  // Reset with a chosen strap, then the documented reset state
  task automatic do_reset(input logic strap);
    @(posedge sys_clk_i);
    srst_i          <= 1'b1;
    small_variant_i <= strap;
    repeat (12) @(posedge sys_clk_i);
    srst_i          <= 1'b0;
    #1;
    check(16'(stack_pointer_o), 16'h0007);
    check(data_pointer_o, 16'h0000);
    check({status_word_o, 4'h0, page_o}, 16'h0000);
  endtask

  // Push, pop, wrap and a stack in the upper half
  task automatic t_stack();
    w(AK_PUSH, 8'h00, 8'h11);
    check(16'(stack_pointer_o), 16'h0008);
    w(AK_PUSH, 8'h00, 8'h22);
    r(AK_DIRECT, 8'h08, 8'h11);
    r(AK_DIRECT, 8'h81, 8'h09);
    r(AK_POP, 8'h00, 8'h22);
    check(16'(stack_pointer_o), 16'h0008);
    w(AK_DIRECT, 8'h81, 8'hff);
    w(AK_PUSH, 8'h00, 8'h33);
    r(AK_DIRECT, 8'h00, 8'h33);
    w(AK_DIRECT, 8'h81, 8'h9f);
    w(AK_PUSH, 8'h00, 8'h44);
    w(AK_REG, 8'h00, 8'ha0);
    r(AK_INDIRECT, 8'h00, 8'h44);
    // Back-to-back strobes: push then pop, write then read of one byte
    eu.req_pair(AK_PUSH, 8'h00, 8'h55, 1'b1, AK_POP, 8'h00, 8'h00, 1'b0);
    check(16'(rdata_o), 16'h0055);
    check(16'(stack_pointer_o), 16'h00a0);
    eu.req_pair(AK_DIRECT, 8'h40, 8'h99, 1'b1, AK_DIRECT, 8'h40, 8'h00, 1'b0);
    check(16'(rdata_o), 16'h0099);
  endtask

  // Every bank code selects its own eight bytes
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      w(AK_DIRECT, 8'hd0, 8'(b << 3));
      check(16'(status_word_o), 16'(b << 3));
      w(AK_REG, 8'h02, 8'(8'h40 + b));
    end
    for (int b = 0; b < 4; b++) begin
      r(AK_DIRECT, 8'(b * 8 + 2), 8'(8'h40 + b));
      w(AK_DIRECT, 8'hd0, 8'(b << 3));
      r(AK_REG, 8'h02, 8'(8'h40 + b));
    end
  endtask

  // Indirect versus direct above 0x7f, and forwarding to outside registers
  task automatic t_indirect();
    w(AK_DIRECT, 8'hd0, 8'h08);
    w(AK_REG, 8'h00, 8'h90);
    w(AK_REG, 8'h01, 8'h35);
    w(AK_INDIRECT, 8'h00, 8'h5a);
    w(AK_INDIRECT, 8'h01, 8'h6b);
    r(AK_DIRECT, 8'h35, 8'h6b);
    r(AK_DIRECT, 8'h90, 8'h00);
    check({7'h00, sfr_fwd_o, 7'h00, sfr_wr_o}, 16'h0100);
    w(AK_DIRECT, 8'h90, 8'hc3);
    check({sfr_fwd_o, sfr_wr_o, 6'h00, fwd_data_o}, 16'hc0c3);
    check(16'(sfr_addr_o), 16'h0090);
    r(AK_INDIRECT, 8'h00, 8'h5a);
  endtask

  // Bit addresses onto bytes 0x20-0x2f, and bit access above the area
  task automatic t_bits();
    w(AK_DIRECT, 8'h22, 8'h00);
    w(AK_DIRECT, 8'h2f, 8'h00);
    w(AK_BIT, 8'h13, 8'h01);
    w(AK_BIT, 8'h7f, 8'h01);
    r(AK_DIRECT, 8'h22, 8'h08);
    r(AK_DIRECT, 8'h2f, 8'h80);
    r(AK_BIT, 8'h13, 8'h01);
    r(AK_BIT, 8'h12, 8'h00);
    r(AK_BIT, 8'h91, 8'h00);
    check({7'h00, sfr_fwd_o, 7'h00, sfr_bit_o}, 16'h0101);
  endtask

  // Both external move forms, aliasing and write redirection
  task automatic t_external_space_ram();
    w(AK_DIRECT, 8'h83, 8'h01);
    w(AK_DIRECT, 8'h82, 8'h23);
    check(data_pointer_o, 16'h0123);
    r(AK_DIRECT, 8'h83, 8'h01);
    w(AK_XDPTR, 8'h00, 8'ha5);
    w(AK_DIRECT, 8'haa, 8'hf1);
    check(16'(page_o), 16'h0001);
    r(AK_DIRECT, 8'haa, 8'h01);
    w(AK_DIRECT, 8'hd0, 8'h10);
    w(AK_REG, 8'h01, 8'h23);
    r(AK_XPAGE, 8'h01, 8'ha5);
    w(AK_REG, 8'h00, 8'h45);
    w(AK_XPAGE, 8'h00, 8'h96);
    r(AK_XPAGE, 8'h00, 8'h96);
    w(AK_DIRECT, 8'h83, 8'h03);
    w(AK_XDPTR, 8'h00, 8'h77);
    w(AK_DIRECT, 8'h83, 8'h11);
    r(AK_XDPTR, 8'h00, 8'ha5);
    w(AK_DIRECT, 8'h83, 8'h01);
    @(posedge sys_clk_i);
    flash_redir_i <= 1'b1;
    w(AK_XDPTR, 8'h00, 8'h3c);
    check(16'(flash_wr_o), 16'h0001);
    check(flash_addr_o, 16'h0123);
    r(AK_XDPTR, 8'h00, 8'ha5);
    @(posedge sys_clk_i);
    flash_redir_i <= 1'b0;
  endtask

  // Small variant aliases at 512 bytes and works straight after reset
  task automatic t_small();
    do_reset(1'b1);
    w(AK_DIRECT, 8'h83, 8'h00);
    w(AK_DIRECT, 8'h82, 8'h05);
    w(AK_XDPTR, 8'h00, 8'h5e);
    w(AK_DIRECT, 8'h83, 8'h02);
    r(AK_XDPTR, 8'h00, 8'h5e);
  endtask

  // Main sequence
  initial begin
    error_cnt       = 0;
    checked         = 0;
    srst_i          = 1'b1;
    small_variant_i = 1'b0;
    flash_redir_i   = 1'b0;
    do_reset(1'b0);
    t_stack();
    t_banks();
    t_indirect();
    t_bits();
    t_external_space_ram();
    t_small();
    test_done();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    $display("MISMATCH at %0t: run did not finish", $time);
    test_done();
  end
endmodule
